// ===== verification/pci_bus_partner.sv
`timescale 1ns/1ps
// ==========
// arbiter and far target
// ==========
module pci_bus_partner (
  input wire logic sys_clk, rst_n, req_n, frame_n, irdy_n, req64_n,
  input wire logic mine, claim, ack_en,
  input wire logic [2:0] wait_cyc,
  input wire logic [3:0] cbe_n,
  input wire logic [63:0] ad,
  output logic gnt_n, devsel_n, trdy_n, ack64_n, ad_oe,
  output logic [35:0] wgot
);
  logic frame_d, act, rd, wide;
  logic [2:0] cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      gnt_n <= 1'b1;
    else
      gnt_n <= req_n;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_d <= 1'b1;
      act <= 1'b0;
      cnt <= 3'h0;
      rd <= 1'b0;
      wide <= 1'b0;
    end else begin
      frame_d <= frame_n;
      if (!frame_n && frame_d && mine && claim) begin
        act <= 1'b1;
        cnt <= wait_cyc;
        rd <= cbe_n[0];
        wide <= ack_en & !req64_n;
      end else if (act && cnt != 3'h0)
        cnt <= cnt - 3'h1;
      else if (act && !devsel_n && !irdy_n)
        act <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      ack64_n <= 1'b1;
      ad_oe <= 1'b0;
      wgot <= '0;
    end else if (act && cnt == 3'h0 && devsel_n) begin
      devsel_n <= 1'b0;
      trdy_n <= 1'b0;
      ack64_n <= ~wide;
      ad_oe <= rd;
    end else if (act && !devsel_n && !irdy_n) begin
      wgot <= {cbe_n, ad[31:0]};
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      ack64_n <= 1'b1;
      ad_oe <= 1'b0;
    end
  end
endmodule // pci_bus_partner

// ===== verification/pci_master_target_port_tb.sv
`timescale 1ns/1ps
// ==========
// bench top
// ==========
module pci_master_target_port_tb;
  import pci_port_pkg::*;
  localparam int INT_W = 8;
  logic sys_clk, rst_n, ad_lo_oe, ad_hi_oe, cbe_lo_oe, cbe_hi_oe;
  logic frame_n_in, frame_n_out, frame_n_oe, irdy_n_in, irdy_n_out;
  logic irdy_n_oe, trdy_n_in, trdy_n_out, trdy_n_oe, devsel_n_in;
  logic devsel_n_out, devsel_n_oe, req64_n_in, req64_n_out, req64_n_oe;
  logic ack64_n_in, ack64_n_out, ack64_n_oe, par_in, par_out, par_oe;
  logic par64_in, par64_out, par64_oe, req_n_out, req_n_oe, gnt_n, idsel;
  logic clkrun_n_in, clkrun_n_out, clkrun_n_oe, inta_n_out, inta_n_oe;
  logic mst_valid, mst_ready, mst_done, mst_abort, rd_valid, rd_ready;
  logic slot64, clk_running, b_oe, b_ad_oe, b_frame_n, b_irdy_n, slot_n;
  logic host_run_n, claim, ack_en, p_devsel_n, p_trdy_n, p_ack64_n;
  logic p_ad_oe, s64, ab, h, stop_clk;
  logic [63:0] ad_in, ad_out, junk, rdata, d;
  logic [63:0] rv [3];
  logic [31:0] b_ad, g, a, w0, w1;
  logic [35:0] wgot;
  logic [7:0] cbe_n_in, cbe_n_out, bv;
  logic [3:0] b_cbe_n;
  logic [2:0] wait_cyc;
  logic [INT_W-1:0] int_pending, int_enable;
  mst_req_t mst_req;
  rd_word_t rd_word;
  rd_word_t rq [$];
  int error_cnt, checks, cyc;

  assign frame_n_in = frame_n_oe ? frame_n_out : b_oe ? b_frame_n : 1'b1;
  assign irdy_n_in = irdy_n_oe ? irdy_n_out : b_oe ? b_irdy_n : 1'b1;
  assign trdy_n_in = trdy_n_oe ? trdy_n_out : p_trdy_n;
  assign devsel_n_in = devsel_n_oe ? devsel_n_out : p_devsel_n;
  assign ack64_n_in = ack64_n_oe ? ack64_n_out : p_ack64_n;
  assign req64_n_in = req64_n_oe ? req64_n_out : slot_n;
  assign ad_in[31:0] = ad_lo_oe ? ad_out[31:0] : b_ad_oe ? b_ad :
    p_ad_oe ? rdata[31:0] : junk[31:0];
  assign ad_in[63:32] = ad_hi_oe ? ad_out[63:32] :
    (p_ad_oe && !p_ack64_n) ? rdata[63:32] : junk[63:32];
  assign cbe_n_in[3:0] = cbe_lo_oe ? cbe_n_out[3:0] : b_oe ? b_cbe_n :
    junk[3:0];
  assign cbe_n_in[7:4] = cbe_hi_oe ? cbe_n_out[7:4] : junk[7:4];
  assign par_in = par_oe ? par_out : junk[8];
  assign par64_in = par64_oe ? par64_out : junk[9];
  assign clkrun_n_in = clkrun_n_oe ? clkrun_n_out : host_run_n;

  pci_master_target_port #(.INT_W(INT_W)) DUT (.*);

  pci_bus_partner far (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_n(req_n_oe ? req_n_out : 1'b1), .frame_n(frame_n_in),
    .irdy_n(irdy_n_in), .req64_n(req64_n_in), .mine(frame_n_oe),
    .claim(claim), .ack_en(ack_en), .wait_cyc(wait_cyc),
    .cbe_n(cbe_n_in[3:0]), .ad(ad_in), .gnt_n(gnt_n),
    .devsel_n(p_devsel_n), .trdy_n(p_trdy_n), .ack64_n(p_ack64_n),
    .ad_oe(p_ad_oe), .wgot(wgot));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    junk <= {$urandom, $urandom};
    host_run_n <= stop_clk | clkrun_n_in;
    cyc <= cyc + 1;
    if (rd_valid && rd_ready)
      rq.push_back(rd_word);
    if (cyc == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic rd_word_t exp_rd(input logic wd, input logic [63:0] r);
    exp_rd.wide = wd & s64 & ack_en;
    exp_rd.data = exp_rd.wide ? r : {32'h0000_0000, r[31:0]};
  endfunction

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic
      [31:0] n, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      if (be[i])
        o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    slot_n <= ~s;
    s64 = s;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    slot_n <= 1'b1;
    @(posedge sys_clk);
    chk(65'(slot64), 65'(s));
  endtask

  task automatic mst_go(input logic wr, wd, input logic [31:0] ad,
      input logic [63:0] dat, input logic [7:0] be);
    int n;
    @(posedge sys_clk);
    mst_valid <= 1'b1;
    mst_req <= '{write: wr, wide: wd, cmd: wr ? CMD_MEM_WR : CMD_MEM_RD,
      addr: ad, data: dat, be: be};
    do @(posedge sys_clk); while (!mst_ready);
    mst_valid <= 1'b0;
    n = 0;
    while (!mst_done && !mst_abort && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    ab = mst_abort;
    chk(65'(n < 60), 65'h1);
    while (!mst_ready) @(posedge sys_clk);
  endtask

  task automatic tgt(input logic [3:0] cmd, input logic [31:0] ad,
      input logic sel, input logic [31:0] wd, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    b_oe <= 1'b1;
    b_ad_oe <= 1'b1;
    b_frame_n <= 1'b0;
    b_ad <= ad;
    b_cbe_n <= ~cmd;
    idsel <= sel;
    @(posedge sys_clk);
    b_frame_n <= 1'b1;
    b_irdy_n <= 1'b0;
    b_ad_oe <= cmd[0];
    b_ad <= wd;
    b_cbe_n <= ~be;
    idsel <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (trdy_n_in && n < 6);
    g = ad_in[31:0];
    h = !trdy_n_in;
    b_irdy_n <= 1'b1;
    b_ad_oe <= 1'b0;
    repeat (2) @(posedge sys_clk);
    b_oe <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rst_n, slot_n, mst_valid, idsel, b_oe, b_ad_oe, stop_clk} = 7'h00;
    {rd_ready, b_frame_n, b_irdy_n, host_run_n, claim, ack_en} = 6'h3F;
    {mst_req, b_ad, b_cbe_n, wait_cyc, rdata, junk} = '0;
    {int_pending, int_enable, error_cnt, checks, cyc} = '0;
    void'($urandom(32'hf1c5_22b9));
    do_reset(1'b1);
    for (int i = 0; i < 6; i++) begin
      wait_cyc <= 3'($urandom_range(2));
      d = {$urandom, $urandom};
      bv = 8'($urandom);
      mst_go(1'b1, 1'($urandom), $urandom & 32'hFFFF_FFFC, d, bv);
      chk(65'(ab), 65'h0);
      chk(65'(wgot), 65'({~bv[3:0], d[31:0]}));
    end
    $display("test master writes done");
    rd_ready <= 1'b0;
    wait_cyc <= 3'h0;
    for (int i = 0; i < 3; i++)
      rv[i] = {$urandom, $urandom};
    rdata <= rv[0];
    mst_go(1'b0, 1'b1, 32'h0000_1000, 64'h0, 8'hFF);
    rdata <= rv[1];
    mst_go(1'b0, 1'b0, 32'h0000_1008, 64'h0, 8'hFF);
    rdata <= rv[2];
    fork
      mst_go(1'b0, 1'b1, 32'h0000_1010, 64'h0, 8'hFF);
      begin
        repeat (20) @(posedge sys_clk);
        chk(65'(irdy_n_in), 65'h1);
        rd_ready <= 1'b1;
      end
    join
    repeat (4) @(posedge sys_clk);
    chk(65'(rq.size()), 65'h3);
    for (int i = 0; i < 3; i++)
      chk(rq.pop_front(), exp_rd(i != 1, rv[i]));
    claim <= 1'b0;
    mst_go(1'b0, 1'b0, 32'h0000_2000, 64'h0, 8'hFF);
    chk(65'(ab), 65'h1);
    claim <= 1'b1;
    $display("test master reads done");
    tgt(CMD_CFG_WR, 32'h0000_0000, 1'b1, $urandom, 4'hF);
    tgt(CMD_CFG_RD, 32'h0000_0000, 1'b1, 32'h0, 4'hF);
    chk({h, 32'h0, g}, {1'b1, 32'h0, CFG_ID_WORD});
    tgt(CMD_CFG_RD, 32'h0000_0000, 1'b0, 32'h0, 4'hF);
    chk(65'(h), 65'h0);
    tgt(CMD_MEM_RD, TGT_BASE + 32'h0000_0040, 1'b0, 32'h0, 4'hF);
    chk(65'(h), 65'h0);
    for (int i = 0; i < 4; i++) begin
      a = TGT_BASE + 32'($urandom_range(15) << TGT_IDX_LSB);
      w0 = $urandom;
      w1 = $urandom;
      bv = 8'($urandom);
      tgt(CMD_MEM_WR, a, 1'b0, w0, 4'hF);
      tgt(CMD_MEM_WR, a, 1'b0, w1, bv[3:0]);
      tgt(CMD_MEM_RD, a, 1'b0, 32'h0, 4'hF);
      chk({h, 32'h0, g}, {1'b1, 32'h0, mrg(w0, w1, bv[3:0])});
    end
    $display("test target done");
    do_reset(1'b0);
    rdata <= {$urandom, $urandom};
    mst_go(1'b0, 1'b1, 32'h0000_3000, 64'h0, 8'hFF);
    repeat (2) @(posedge sys_clk);
    chk(rq.pop_front(), exp_rd(1'b1, rdata));
    for (int i = 0; i < 8; i++) begin
      int_pending <= INT_W'($urandom);
      int_enable <= INT_W'($urandom);
      repeat (3) @(posedge sys_clk);
      chk(65'(inta_n_oe), 65'(|(int_pending & int_enable)));
    end
    int_pending <= '0;
    stop_clk <= 1'b1;
    repeat (2) @(posedge sys_clk);
    stop_clk <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(65'(clk_running), 65'h0);
    int_pending <= '1;
    int_enable <= '1;
    repeat (4) @(posedge sys_clk);
    chk(65'(clk_running), 65'h1);
    $display("test slot and interrupt done");
    report_and_stop();
  end
endmodule // pci_master_target_port_tb

// ===== verification/pci_port_chk.sv
`timescale 1ns/1ps
// ==========
// port checker
// ==========
module pci_port_chk
  import pci_port_pkg::*;
#(
  parameter int INT_W = 8
) (
  input wire logic sys_clk, rst_n, ad_lo_oe, cbe_lo_oe, ad_hi_oe,
  input wire logic frame_n_in, frame_n_out, frame_n_oe, irdy_n_out,
  input wire logic irdy_n_oe, trdy_n_in, trdy_n_out, devsel_n_in,
  input wire logic devsel_n_out, devsel_n_oe, ack64_n_oe, par_out,
  input wire logic par_oe, par64_oe, par64_out, gnt_n, req_n_out, req_n_oe,
  input wire logic idsel, inta_n_oe, mst_done,
  input wire logic [63:0] ad_in, ad_out,
  input wire logic [7:0] cbe_n_in, cbe_n_out,
  input wire logic [INT_W-1:0] int_pending, int_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  int_follow_a: assert property (
    1'b1 |=> inta_n_oe == |($past(int_pending) & $past(int_enable)))
    else $error("interrupt pin not following enabled causes");
  no_ack64_a: assert property (!ack64_n_oe)
    else $error("wide acknowledge driven as target");
  frame_grant_a: assert property (
    $rose(frame_n_oe) |-> !$past(gnt_n) && $past(req_n_oe) &&
      !$past(req_n_out))
    else $error("frame started without request and grant");
  par_mst_a: assert property (
    $past(ad_lo_oe) && $past(cbe_lo_oe) |-> par_oe &&
      par_out == ^{$past(ad_out[31:0]), $past(cbe_n_out[3:0])})
    else $error("low parity wrong as master");
  par_tgt_a: assert property (
    $past(ad_lo_oe) && !$past(cbe_lo_oe) |-> par_oe &&
      par_out == ^{$past(ad_out[31:0]), $past(cbe_n_in[3:0])})
    else $error("low parity wrong as target");
  par64_own_a: assert property (
    par64_oe |-> $past(ad_hi_oe) &&
      par64_out == ^{$past(ad_out[63:32]), $past(cbe_n_out[7:4])})
    else $error("upper parity without upper lines");
  frame_last_a: assert property (
    frame_n_oe |-> frame_n_out == !irdy_n_out)
    else $error("frame held past single data phase");
  done_xfer_a: assert property (
    irdy_n_oe && !irdy_n_out && !trdy_n_in && !devsel_n_in |=> mst_done)
    else $error("completed transfer not reported");
  cfg_idsel_a: assert property (
    $fell(frame_n_in) && !frame_n_oe && !idsel &&
      ~cbe_n_in[3:1] == CMD_CFG_RD[3:1] |=> !devsel_n_oe)
    else $error("config cycle claimed without idsel");
  tgt_claim_a: assert property (
    $fell(frame_n_in) && !frame_n_oe && idsel && ad_in[1:0] == 2'h0 &&
      ~cbe_n_in[3:0] == CMD_CFG_RD |=>
      devsel_n_oe && !devsel_n_out && !trdy_n_out)
    else $error("config read not claimed");
endmodule // pci_port_chk

bind pci_master_target_port pci_port_chk #(.INT_W(INT_W)) chk (.*);

// ===== verilog/pci_master_target_port.sv
// Functional notes
// - all timing taken from bus clock, 66MHz; sys_clk here runs at 200MHz (SYS_CLK_MHZ)
// - pull clock-run low, read its status
// - master checks device select claims transfer
// - target drives device select after decode
// - frame low until last data phase
// - target decodes only seen transaction starts
// - request low before mastering the bus
// - assert req64 for wide master transfers
// - req64 at reset release sets slot width
// - config cycles only with idsel asserted
// - interrupt pin low on enabled pending cause
// - initiator ready only when phase can complete
// - target ready only when phase can complete
// - word moves when both readies low
// - even parity over low lines and par
// - parity one clock after its phase
// - par driven for own driven phases
// - even parity over upper lines and par64
// - target never drives par64
// - address phase is first frame clock
// - command in address, enables in data
`timescale 1ns/1ps

module pci_master_target_port #(
  parameter int INT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [63:0] ad_in,
  output logic [63:0] ad_out,
  output logic ad_lo_oe,
  output logic ad_hi_oe,
  input wire logic [7:0] cbe_n_in,
  output logic [7:0] cbe_n_out,
  output logic cbe_lo_oe,
  output logic cbe_hi_oe,
  input wire logic frame_n_in,
  output logic frame_n_out,
  output logic frame_n_oe,
  input wire logic irdy_n_in,
  output logic irdy_n_out,
  output logic irdy_n_oe,
  input wire logic trdy_n_in,
  output logic trdy_n_out,
  output logic trdy_n_oe,
  input wire logic devsel_n_in,
  output logic devsel_n_out,
  output logic devsel_n_oe,
  input wire logic req64_n_in,
  output logic req64_n_out,
  output logic req64_n_oe,
  input wire logic ack64_n_in,
  output logic ack64_n_out,
  output logic ack64_n_oe,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe,
  input wire logic par64_in,
  output logic par64_out,
  output logic par64_oe,
  output logic req_n_out,
  output logic req_n_oe,
  input wire logic gnt_n,
  input wire logic idsel,
  input wire logic clkrun_n_in,
  output logic clkrun_n_out,
  output logic clkrun_n_oe,
  output logic inta_n_out,
  output logic inta_n_oe,
  input wire logic [INT_W-1:0] int_pending,
  input wire logic [INT_W-1:0] int_enable,
  input wire logic mst_valid,
  input wire pci_port_pkg::mst_req_t mst_req,
  output logic mst_ready,
  output logic mst_done,
  output logic mst_abort,
  output logic rd_valid,
  output pci_port_pkg::rd_word_t rd_word,
  input wire logic rd_ready,
  output logic slot64,
  output logic clk_running
);
  import pci_port_pkg::*;

  // ==========================================================
  // bus observation
  // ==========================================================
  logic frame_q_r;
  logic slot_taken_r;
  logic addr_phase;
  logic bus_idle;
  logic [3:0] cmd_in;
  mst_state_t m_state_r;
  tgt_state_t t_state_r;
  mst_req_t cur_r;
  logic [3:0] dsel_cnt_r;
  logic wide_ok_r;
  logic m_xfer;
  logic t_xfer;
  logic rd_push;
  logic rd_pop;
  logic buf_room;
  rd_word_t push_word;
  rd_word_t tail_r;
  logic tail_valid_r;
  logic [31:0] tgt_mem_r [TGT_WORDS];
  logic [TGT_IDX_W-1:0] t_idx_r;
  logic t_cfg_r;
  logic t_write_r;
  logic t_hit;
  logic t_cfg_hit;
  logic t_mem_hit;
  logic [31:0] t_rdata;
  logic [3:0] par_cbe_lo;
  logic [3:0] par_cbe_hi;

  assign cmd_in = ~cbe_n_in[3:0];
  assign bus_idle = frame_n_in & irdy_n_in;

  assign addr_phase = ~frame_n_in & frame_q_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q_r <= 1'b1;
    end else begin
      frame_q_r <= frame_n_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_taken_r <= 1'b0;
      slot64 <= 1'b0;
    end else if (!slot_taken_r) begin
      slot_taken_r <= 1'b1;
      slot64 <= ~req64_n_in;
    end
  end

  // ==========================================================
  // master side
  // ==========================================================
  // word moves on both readies
  assign m_xfer = (m_state_r == M_DATA) & ~irdy_n_out & irdy_n_oe
    & ~trdy_n_in & ~devsel_n_in;
  assign buf_room = ~tail_valid_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state_r <= M_IDLE;
      cur_r <= '0;
      mst_ready <= 1'b1;
      mst_done <= 1'b0;
      mst_abort <= 1'b0;
      dsel_cnt_r <= 4'h0;
      wide_ok_r <= 1'b0;
      req_n_out <= 1'b1;
      req_n_oe <= 1'b0;
      frame_n_out <= 1'b1;
      frame_n_oe <= 1'b0;
      irdy_n_out <= 1'b1;
      irdy_n_oe <= 1'b0;
      req64_n_out <= 1'b1;
      req64_n_oe <= 1'b0;
    end else begin
      mst_done <= 1'b0;
      mst_abort <= 1'b0;
      case (m_state_r)
        M_IDLE: begin
          if (mst_valid && mst_ready) begin
            cur_r <= mst_req;
            cur_r.wide <= mst_req.wide & slot64;
            mst_ready <= 1'b0;
            req_n_out <= 1'b0;
            req_n_oe <= 1'b1;
            m_state_r <= M_REQ;
          end
        end
        M_REQ: begin
          if (!gnt_n && bus_idle && t_state_r == T_IDLE) begin
            req_n_out <= 1'b1;
            frame_n_out <= 1'b0;
            frame_n_oe <= 1'b1;
            irdy_n_out <= 1'b1;
            irdy_n_oe <= 1'b1;
            req64_n_out <= ~cur_r.wide;
            req64_n_oe <= 1'b1;
            dsel_cnt_r <= 4'h0;
            wide_ok_r <= 1'b0;
            m_state_r <= M_ADDR;
          end
        end
        M_ADDR: begin
          m_state_r <= M_DATA;
          if (cur_r.write || buf_room) begin
            irdy_n_out <= 1'b0;
            frame_n_out <= 1'b1;
            req64_n_out <= 1'b1;
          end
        end
        M_DATA: begin
          dsel_cnt_r <= dsel_cnt_r + 4'h1;
          if (!devsel_n_in) begin
            wide_ok_r <= ~ack64_n_in;
          end
          if (irdy_n_out && (cur_r.write || buf_room)) begin
            irdy_n_out <= 1'b0;
            frame_n_out <= 1'b1;
            req64_n_out <= 1'b1;
          end
          if (m_xfer) begin
            mst_done <= 1'b1;
            irdy_n_out <= 1'b1;
            frame_n_oe <= 1'b0;
            m_state_r <= M_TURN;
          end else if (devsel_n_in && dsel_cnt_r == DEVSEL_WAIT_CYC) begin
            mst_abort <= 1'b1;
            irdy_n_out <= 1'b1;
            frame_n_out <= 1'b1;
            frame_n_oe <= 1'b0;
            req64_n_out <= 1'b1;
            m_state_r <= M_TURN;
          end
        end
        M_TURN: begin
          irdy_n_oe <= 1'b0;
          req64_n_oe <= 1'b0;
          req_n_oe <= 1'b0;
          mst_ready <= 1'b1;
          m_state_r <= M_IDLE;
        end
        default: begin
          m_state_r <= M_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // read word buffer, two entries
  // ==========================================================
  assign rd_push = m_xfer & ~cur_r.write;
  assign rd_pop = rd_valid & rd_ready;
  assign push_word.wide = ~ack64_n_in & ~devsel_n_in;
  assign push_word.data = {(ack64_n_in ? WORD_RST : ad_in[63:32]),
    ad_in[31:0]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_word <= '0;
      tail_valid_r <= 1'b0;
      tail_r <= '0;
    end else begin
      if (rd_pop || !rd_valid) begin
        rd_valid <= tail_valid_r | rd_push;
        rd_word <= tail_valid_r ? tail_r : push_word;
        tail_valid_r <= tail_valid_r & rd_push;
        tail_r <= push_word;
      end else if (rd_push) begin
        tail_valid_r <= 1'b1;
        tail_r <= push_word;
      end
    end
  end

  // ==========================================================
  // target side
  // ==========================================================
  // config only with idsel
  assign t_cfg_hit = idsel & (ad_in[1:0] == CFG_TYPE0)
    & ((cmd_in == CMD_CFG_RD) | (cmd_in == CMD_CFG_WR));
  assign t_mem_hit = ((cmd_in == CMD_MEM_RD) | (cmd_in == CMD_MEM_WR))
    & (ad_in[31:TGT_IDX_W+TGT_IDX_LSB] ==
       TGT_BASE[31:TGT_IDX_W+TGT_IDX_LSB]);
  assign t_hit = addr_phase & (m_state_r != M_ADDR)
    & (m_state_r != M_DATA) & (t_cfg_hit | t_mem_hit);
  assign t_xfer = (t_state_r == T_DATA) & ~trdy_n_out & ~irdy_n_in;

  always_comb begin
    t_rdata = tgt_mem_r[t_idx_r];
    if (t_cfg_r) begin
      t_rdata = (t_idx_r == CFG_ID_IDX) ? CFG_ID_WORD : WORD_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_state_r <= T_IDLE;
      t_idx_r <= '0;
      t_cfg_r <= 1'b0;
      t_write_r <= 1'b0;
      devsel_n_out <= 1'b1;
      devsel_n_oe <= 1'b0;
      trdy_n_out <= 1'b1;
      trdy_n_oe <= 1'b0;
      ack64_n_out <= 1'b1;
      ack64_n_oe <= 1'b0;
    end else begin
      case (t_state_r)
        T_IDLE: begin
          if (t_hit) begin
            t_idx_r <= ad_in[TGT_IDX_W+TGT_IDX_LSB-1:TGT_IDX_LSB];
            t_cfg_r <= t_cfg_hit;
            t_write_r <= cmd_in[0];
            devsel_n_out <= 1'b0;
            devsel_n_oe <= 1'b1;
            trdy_n_out <= 1'b0;
            trdy_n_oe <= 1'b1;
            t_state_r <= T_DATA;
          end
        end
        T_DATA: begin
          if (t_xfer) begin
            t_idx_r <= t_idx_r + 1'b1;
            if (frame_n_in) begin
              devsel_n_out <= 1'b1;
              trdy_n_out <= 1'b1;
              t_state_r <= T_TURN;
            end
          end
        end
        T_TURN: begin
          devsel_n_oe <= 1'b0;
          trdy_n_oe <= 1'b0;
          t_state_r <= T_IDLE;
        end
        default: begin
          t_state_r <= T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < TGT_WORDS; i++) begin
        tgt_mem_r[i] <= WORD_RST;
      end
    end else if (t_xfer && t_write_r && !t_cfg_r) begin
      for (int b = 0; b < 4; b++) begin
        if (!cbe_n_in[b]) begin
          tgt_mem_r[t_idx_r][8*b +: 8] <= ad_in[8*b +: 8];
        end
      end
    end
  end

  // ==========================================================
  // address/data and command drive
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out <= DWORD_RST;
      ad_lo_oe <= 1'b0;
      ad_hi_oe <= 1'b0;
      cbe_n_out <= 8'hFF;
      cbe_lo_oe <= 1'b0;
      cbe_hi_oe <= 1'b0;
    end else begin
      ad_lo_oe <= 1'b0;
      ad_hi_oe <= 1'b0;
      cbe_lo_oe <= 1'b0;
      cbe_hi_oe <= 1'b0;
      if (m_state_r == M_REQ && !gnt_n && bus_idle
          && t_state_r == T_IDLE) begin
        ad_out <= {WORD_RST, cur_r.addr};
        cbe_n_out <= {~cur_r.cmd, ~cur_r.cmd};
        ad_lo_oe <= 1'b1;
        ad_hi_oe <= cur_r.wide;
        cbe_lo_oe <= 1'b1;
        cbe_hi_oe <= cur_r.wide;
      end else if (m_state_r == M_ADDR ||
                   (m_state_r == M_DATA && !m_xfer && !mst_abort
                    && !(devsel_n_in && dsel_cnt_r == DEVSEL_WAIT_CYC))) begin
        ad_out <= cur_r.data;
        cbe_n_out <= ~cur_r.be;
        ad_lo_oe <= cur_r.write;
        ad_hi_oe <= cur_r.write & cur_r.wide;
        cbe_lo_oe <= 1'b1;
        cbe_hi_oe <= cur_r.wide;
      end else if ((t_state_r == T_IDLE && t_hit && !cmd_in[0]) ||
                   (t_state_r == T_DATA && !t_write_r
                    && !(t_xfer && frame_n_in))) begin
        ad_out <= {WORD_RST, t_state_r == T_IDLE ?
          ((t_cfg_hit && ad_in[5:2] == CFG_ID_IDX) ? CFG_ID_WORD :
           (t_cfg_hit ? WORD_RST :
            tgt_mem_r[ad_in[TGT_IDX_W+TGT_IDX_LSB-1:TGT_IDX_LSB]])) :
          (t_xfer ? tgt_mem_r[t_idx_r + 1'b1] : t_rdata)};
        ad_lo_oe <= 1'b1;
      end
    end
  end

  // ==========================================================
  // parity
  // ==========================================================
  assign par_cbe_lo = cbe_lo_oe ? cbe_n_out[3:0] : cbe_n_in[3:0];
  assign par_cbe_hi = cbe_hi_oe ? cbe_n_out[7:4] : cbe_n_in[7:4];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_out <= 1'b0;
      par_oe <= 1'b0;
      par64_out <= 1'b0;
      par64_oe <= 1'b0;
    end else begin
      par_out <= ^{ad_out[31:0], par_cbe_lo};
      par_oe <= ad_lo_oe;
      par64_out <= ^{ad_out[63:32], par_cbe_hi};
      par64_oe <= ad_hi_oe;
    end
  end

  // ==========================================================
  // clock run and interrupt pins
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkrun_n_out <= 1'b0;
      clkrun_n_oe <= 1'b0;
      clk_running <= 1'b0;
      inta_n_out <= 1'b0;
      inta_n_oe <= 1'b0;
    end else begin
      clk_running <= ~clkrun_n_in;
      clkrun_n_oe <= clkrun_n_in & ((m_state_r != M_IDLE)
        | (t_state_r != T_IDLE) | (|(int_pending & int_enable)));
      inta_n_oe <= |(int_pending & int_enable);
    end
  end

endmodule // pci_master_target_port

// ===== verilog/pci_port_pkg.sv
package pci_port_pkg;

  // ==========================================================
  // bus clock and timing
  // ==========================================================
  localparam int BUS_MAX_MHZ = 66;
  localparam int SYS_CLK_MHZ = 200;
  localparam int SYS_CLK_PS = 5000;
  localparam int DEVSEL_WAIT_NS = 25;
  localparam logic [3:0] DEVSEL_WAIT_CYC =
    4'((DEVSEL_WAIT_NS * 1000) / SYS_CLK_PS);

  // ==========================================================
  // bus commands
  // ==========================================================
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;

  // ==========================================================
  // target space layout
  // ==========================================================
  localparam int TGT_WORDS = 16;
  localparam int TGT_IDX_W = 4;
  localparam int TGT_IDX_LSB = 2;
  localparam logic [31:0] TGT_BASE = 32'h8000_0000;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [TGT_IDX_W-1:0] CFG_ID_IDX = 4'h0;
  // arbitrary identity word
  localparam logic [31:0] CFG_ID_WORD = 32'h0001_0002;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [63:0] DWORD_RST = 64'h0000_0000_0000_0000;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic write;
    logic wide;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0] be;
  } mst_req_t;

  typedef struct packed {
    logic wide;
    logic [63:0] data;
  } rd_word_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic [31:0] addr;
  } addr_phase_t;

  typedef enum logic [2:0] {
    M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN
  } mst_state_t;

  typedef enum logic [1:0] {
    T_IDLE, T_DATA, T_TURN
  } tgt_state_t;

endpackage
